// File: hw/bcrf_map.svh
// Constants for the banked core register file
`ifndef BCRF_MAP_SVH
`define BCRF_MAP_SVH
`define BCRF_NUM_GPR 31
`define BCRF_NUM_PSR 6
`define BCRF_NUM_SAVED 5
`define BCRF_IDX_SP 4'hd
`define BCRF_IDX_LINK 4'he
`define BCRF_IDX_PC 4'hf
`define BCRF_IDX_HI_FIRST 4'h8
`define BCRF_MODE_USR 5'h10
`define BCRF_MODE_FIQ 5'h11
`define BCRF_MODE_IRQ 5'h12
`define BCRF_MODE_SVC 5'h13
`define BCRF_MODE_ABT 5'h17
`define BCRF_MODE_UND 5'h1b
`define BCRF_MODE_SYS 5'h1f
`define BCRF_MODE_LSB 0
`define BCRF_MODE_MSB 4
`define BCRF_STATUS_RESET 32'h000001d3
`define BCRF_PC_RESET 32'h00000000
`endif

// File: hw/bcrf_pkg.sv
// Types for the banked core register file
`default_nettype none
package bcrf_pkg;
  typedef enum logic [1:0] {
    BCRF_ST_WORD = 2'h0,
    BCRF_ST_HALF = 2'h1,
    BCRF_ST_BYTE = 2'h2
  } bcrf_state_t;
  typedef enum logic [2:0] {
    BCRF_BANK_USR = 3'h0,
    BCRF_BANK_FIQ = 3'h1,
    BCRF_BANK_IRQ = 3'h2,
    BCRF_BANK_SVC = 3'h3,
    BCRF_BANK_ABT = 3'h4,
    BCRF_BANK_UND = 3'h5
  } bcrf_bank_t;
  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic user_bank;
    logic [31:0] data;
  } bcrf_wr_t;
  typedef struct packed {
    logic [3:0] idx;
    logic user_bank;
    logic high_variant;
  } bcrf_rd_t;
  typedef struct packed {
    logic link_en;
    logic [31:0] link_addr;
    logic exc_en;
    logic [4:0] exc_mode;
    logic [31:0] exc_return;
    logic status_en;
    logic [31:0] status_data;
    logic saved_en;
    logic [31:0] saved_data;
    logic pc_en;
    logic [31:0] pc_data;
  } bcrf_ctl_t;
endpackage : bcrf_pkg
`default_nettype wire

// File: hw/bcrf_core.sv
// Mode-banked core register file
// Behaviour
// - 37 registers: 31 general, six status
// - Visible registers follow state and mode
// - Word state: 16 slots, one/two status
// - Indices 0-12 are plain storage
// - Index 13 stack pointer, banked per mode
// - Branch-with-link writes return to index 14
// - Exceptions write banked link of mode
// - Program counter aligned per execution state
// - One current status register, always visible
// - Saved status only in privileged modes
// - User and system share user set
// - Fast interrupt banks indices 8 to 14
// - Other exception modes bank 13, 14
// - Halfword state: low registers plus specials
// - Halfword state maps same physical registers
// - High registers readable only via special variants, never writable
// - Seven modes recognised, all but user privileged
`timescale 1ns/1ps
`default_nettype none
`include "bcrf_map.svh"
module bcrf_core #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire bcrf_pkg::bcrf_state_t EXEC_STATE,
  input wire bcrf_pkg::bcrf_rd_t RD_A,
  input wire bcrf_pkg::bcrf_rd_t RD_B,
  input wire bcrf_pkg::bcrf_wr_t WR,
  input wire bcrf_pkg::bcrf_ctl_t CTL,
  output logic [WIDTH-1:0] RD_A_DATA,
  output logic [WIDTH-1:0] RD_B_DATA,
  output logic RD_A_DENIED,
  output logic RD_B_DENIED,
  output logic [WIDTH-1:0] STATUS,
  output logic [WIDTH-1:0] SAVED_STATUS,
  output logic SAVED_VALID,
  output logic [WIDTH-1:0] PROGRAM_COUNTER,
  output logic PRIVILEGED
);
  import bcrf_pkg::*;

  // ----------------------------------------
  // Physical storage
  // ----------------------------------------
  // 0..15 user set (15 = pc), 16..22 fiq 8..14, 23..30 irq/svc/abt/und 13,14
  logic [WIDTH-1:0] gpr_r [0:`BCRF_NUM_GPR-1];
  logic [WIDTH-1:0] status_r;
  logic [WIDTH-1:0] saved_r [0:`BCRF_NUM_SAVED-1];

  // ----------------------------------------
  // Mode and bank decode
  // ----------------------------------------
  function automatic bcrf_bank_t mode_bank(input logic [4:0] m);
    unique case (m)
      `BCRF_MODE_FIQ: mode_bank = BCRF_BANK_FIQ;
      `BCRF_MODE_IRQ: mode_bank = BCRF_BANK_IRQ;
      `BCRF_MODE_SVC: mode_bank = BCRF_BANK_SVC;
      `BCRF_MODE_ABT: mode_bank = BCRF_BANK_ABT;
      `BCRF_MODE_UND: mode_bank = BCRF_BANK_UND;
      default: mode_bank = BCRF_BANK_USR; // user and system
    endcase
  endfunction : mode_bank

  // Physical index of architectural register in given bank
  function automatic logic [4:0] phys_idx(input logic [3:0] idx, input bcrf_bank_t b);
    logic [4:0] p;
    p = {1'b0, idx};
    if (b == BCRF_BANK_FIQ && idx >= `BCRF_IDX_HI_FIRST && idx != `BCRF_IDX_PC) begin
      p = {1'b0, idx} + 5'h08;
    end else if (b != BCRF_BANK_USR && b != BCRF_BANK_FIQ && (idx == `BCRF_IDX_SP || idx == `BCRF_IDX_LINK)) begin
      p = 5'(5'h17 + {(b - 3'h2) & 3'h3, 1'b0} + {4'h0, idx == `BCRF_IDX_LINK});
    end
    phys_idx = p;
  endfunction : phys_idx

  function automatic logic [2:0] saved_idx(input bcrf_bank_t b);
    saved_idx = 3'(b - 3'h1);
  endfunction : saved_idx

  function automatic logic rd_denied(input bcrf_rd_t r, input bcrf_state_t s);
    rd_denied = (s == BCRF_ST_HALF) && r.idx[3] && !r.high_variant && r.idx < `BCRF_IDX_SP;
  endfunction : rd_denied

  wire logic [4:0] cur_mode = status_r[`BCRF_MODE_MSB:`BCRF_MODE_LSB];
  wire bcrf_bank_t cur_bank = mode_bank(cur_mode);
  wire logic mode_legal = cur_mode inside {`BCRF_MODE_USR, `BCRF_MODE_FIQ, `BCRF_MODE_IRQ, `BCRF_MODE_SVC,
                                           `BCRF_MODE_ABT, `BCRF_MODE_UND, `BCRF_MODE_SYS};
  wire logic priv = mode_legal && cur_mode != `BCRF_MODE_USR;
  wire logic has_saved = cur_bank != BCRF_BANK_USR;
  wire bcrf_bank_t exc_bank = mode_bank(CTL.exc_mode);

  // ----------------------------------------
  // Read selection
  // ----------------------------------------
  wire bcrf_bank_t rd_a_bank = (RD_A.user_bank && priv) ? BCRF_BANK_USR : cur_bank;
  wire bcrf_bank_t rd_b_bank = (RD_B.user_bank && priv) ? BCRF_BANK_USR : cur_bank;
  wire logic [4:0] rd_a_phys = phys_idx(RD_A.idx, rd_a_bank);
  wire logic [4:0] rd_b_phys = phys_idx(RD_B.idx, rd_b_bank);
  wire logic rd_a_deny = rd_denied(RD_A, EXEC_STATE);
  wire logic rd_b_deny = rd_denied(RD_B, EXEC_STATE);
  wire logic [WIDTH-1:0] rd_a_val = rd_a_deny ? '0 : gpr_r[rd_a_phys];
  wire logic [WIDTH-1:0] rd_b_val = rd_b_deny ? '0 : gpr_r[rd_b_phys];

  // ----------------------------------------
  // Write selection
  // ----------------------------------------
  wire bcrf_bank_t wr_bank = (WR.user_bank && priv) ? BCRF_BANK_USR : cur_bank;
  wire logic [4:0] wr_phys = phys_idx(WR.idx, wr_bank);
  wire logic wr_ok = WR.en && WR.idx != `BCRF_IDX_PC && !rd_denied('{idx: WR.idx, user_bank: 1'b0,
                     high_variant: 1'b0}, EXEC_STATE);
  wire logic [4:0] link_phys = phys_idx(`BCRF_IDX_LINK, cur_bank);
  wire logic [4:0] exc_link_phys = phys_idx(`BCRF_IDX_LINK, exc_bank);
  wire logic [1:0] pc_mask = (EXEC_STATE == BCRF_ST_WORD) ? 2'h3 : (EXEC_STATE == BCRF_ST_HALF) ? 2'h1 : 2'h0;
  wire logic [WIDTH-1:0] pc_aligned = {CTL.pc_data[WIDTH-1:2], CTL.pc_data[1:0] & ~pc_mask};
  wire logic exc_saved_ok = CTL.exc_en && exc_bank != BCRF_BANK_USR;

  // ----------------------------------------
  // Storage update
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < `BCRF_NUM_GPR; i++) begin
        gpr_r[i] <= '0;
      end
    end else begin
      if (wr_ok) begin
        gpr_r[wr_phys] <= WR.data;
      end
      if (CTL.link_en) begin
        gpr_r[link_phys] <= CTL.link_addr;
      end
      if (CTL.exc_en) begin
        gpr_r[exc_link_phys] <= CTL.exc_return;
      end
      if (CTL.pc_en) begin
        gpr_r[`BCRF_IDX_PC] <= pc_aligned;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      status_r <= `BCRF_STATUS_RESET;
    end else if (CTL.exc_en) begin
      status_r <= {status_r[WIDTH-1:5], CTL.exc_mode};
    end else if (CTL.status_en) begin
      status_r <= CTL.status_data;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < `BCRF_NUM_SAVED; i++) begin
        saved_r[i] <= '0;
      end
    end else if (exc_saved_ok) begin
      saved_r[saved_idx(exc_bank)] <= status_r;
    end else if (CTL.saved_en && has_saved) begin
      saved_r[saved_idx(cur_bank)] <= CTL.saved_data;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RD_A_DATA <= '0;
      RD_B_DATA <= '0;
      RD_A_DENIED <= 1'b0;
      RD_B_DENIED <= 1'b0;
      STATUS <= '0;
      SAVED_STATUS <= '0;
      SAVED_VALID <= 1'b0;
      PROGRAM_COUNTER <= '0;
      PRIVILEGED <= 1'b0;
    end else begin
      RD_A_DATA <= rd_a_val;
      RD_B_DATA <= rd_b_val;
      RD_A_DENIED <= rd_a_deny;
      RD_B_DENIED <= rd_b_deny;
      STATUS <= status_r;
      SAVED_STATUS <= has_saved ? saved_r[saved_idx(cur_bank)] : '0;
      SAVED_VALID <= has_saved;
      PROGRAM_COUNTER <= gpr_r[`BCRF_IDX_PC];
      PRIVILEGED <= priv;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  chk_saved_hidden: assert property (!has_saved |=> !SAVED_VALID && SAVED_STATUS == '0)
    else $error("saved status visible in user set");
  chk_status_follows: assert property (CTL.status_en && !CTL.exc_en |=> status_r == $past(CTL.status_data))
    else $error("status write lost");
  chk_link_write: assert property (CTL.link_en && !CTL.exc_en && !(wr_ok && wr_phys == link_phys)
    |=> gpr_r[$past(link_phys)] == $past(CTL.link_addr))
    else $error("link write lost");
  chk_exc_link: assert property (CTL.exc_en |=> gpr_r[$past(exc_link_phys)] == $past(CTL.exc_return))
    else $error("exception link lost");
  chk_fiq_bank: assert property (cur_bank == BCRF_BANK_FIQ && RD_A.idx == 4'h8 && !RD_A.user_bank
    |-> rd_a_phys == 5'h10)
    else $error("fiq bank mapping wrong");
  chk_svc_bank: assert property (cur_bank == BCRF_BANK_SVC && RD_A.idx == `BCRF_IDX_SP && !RD_A.user_bank
    |-> rd_a_phys == 5'h19)
    else $error("svc stack mapping wrong");
  chk_low_shared: assert property (RD_A.idx < 4'h8 |-> rd_a_phys == {1'b0, RD_A.idx})
    else $error("low register banked");
  chk_pc_align: assert property (CTL.pc_en && EXEC_STATE == BCRF_ST_WORD |=> gpr_r[`BCRF_IDX_PC][1:0] == 2'h0)
    else $error("pc not word aligned");
  chk_half_deny: assert property (EXEC_STATE == BCRF_ST_HALF && RD_A.idx == 4'h9 && !RD_A.high_variant
    |=> RD_A_DENIED && RD_A_DATA == '0)
    else $error("high register reached");
  chk_user_priv: assert property (cur_mode == `BCRF_MODE_USR |=> !PRIVILEGED)
    else $error("user mode privileged");

  // ----------------------------------------
  // Reference slot table
  // ----------------------------------------
  function automatic logic [4:0] ref_slot(input logic [3:0] idx, input bcrf_bank_t b);
    logic [4:0] base;
    logic [4:0] s;
    base = 5'h00;
    s = {1'b0, idx};
    unique case (b)
      BCRF_BANK_USR: base = 5'h00;
      BCRF_BANK_FIQ: base = 5'h10;
      BCRF_BANK_IRQ: base = 5'h17;
      BCRF_BANK_SVC: base = 5'h19;
      BCRF_BANK_ABT: base = 5'h1b;
      BCRF_BANK_UND: base = 5'h1d;
      default: base = 5'h00;
    endcase
    if (b == BCRF_BANK_FIQ && idx >= 4'h8 && idx <= 4'he) begin
      s = base + {1'b0, idx - 4'h8};
    end else if (base != 5'h00 && b != BCRF_BANK_FIQ && idx == 4'hd) begin
      s = base;
    end else if (base != 5'h00 && b != BCRF_BANK_FIQ && idx == 4'he) begin
      s = base + 5'h01;
    end
    ref_slot = s;
  endfunction : ref_slot

  // ----------------------------------------
  // Bank mapping checks
  // ----------------------------------------
  chk_map_rd_a: assert property (
    rd_a_phys == ref_slot(RD_A.idx, rd_a_bank))
    else $error("read port a slot wrong");
  chk_map_rd_b: assert property (
    rd_b_phys == ref_slot(RD_B.idx, rd_b_bank))
    else $error("read port b slot wrong");
  chk_map_wr: assert property (
    wr_phys == ref_slot(WR.idx, wr_bank))
    else $error("write slot wrong");
  chk_slot_range: assert property (
    rd_a_phys < 5'(`BCRF_NUM_GPR) && rd_b_phys < 5'(`BCRF_NUM_GPR) && wr_phys < 5'(`BCRF_NUM_GPR))
    else $error("slot outside storage");
  chk_user_bank: assert property (
    priv && RD_A.user_bank |-> rd_a_bank == BCRF_BANK_USR)
    else $error("user set not selected");
  chk_user_bank_unpriv: assert property (
    !priv |-> rd_b_bank == cur_bank && wr_bank == cur_bank)
    else $error("user set request honoured unprivileged");
  chk_sys_unbanked: assert property (
    cur_mode == `BCRF_MODE_SYS |-> cur_bank == BCRF_BANK_USR)
    else $error("system mode banked");
  chk_mode_illegal: assert property (
    !mode_legal |-> cur_bank == BCRF_BANK_USR && !priv)
    else $error("illegal mode privileged");
  chk_irq_stack: assert property (
    cur_bank == BCRF_BANK_IRQ && RD_A.idx == `BCRF_IDX_SP && !RD_A.user_bank |-> rd_a_phys == 5'h17)
    else $error("irq stack mapping wrong");
  chk_abt_bank: assert property (
    cur_bank == BCRF_BANK_ABT && RD_A.idx == `BCRF_IDX_SP && !RD_A.user_bank |-> rd_a_phys == 5'h1b)
    else $error("abort stack mapping wrong");
  chk_und_link: assert property (
    cur_bank == BCRF_BANK_UND && RD_A.idx == `BCRF_IDX_LINK && !RD_A.user_bank |-> rd_a_phys == 5'h1e)
    else $error("undefined link mapping wrong");
  chk_fiq_link: assert property (
    CTL.exc_en && CTL.exc_mode == `BCRF_MODE_FIQ |-> exc_link_phys == 5'h16)
    else $error("fiq link slot wrong");
  chk_link_bank: assert property (
    CTL.link_en |-> link_phys == ref_slot(`BCRF_IDX_LINK, cur_bank))
    else $error("link slot wrong");
  chk_exc_slot: assert property (
    CTL.exc_en |-> exc_link_phys == ref_slot(`BCRF_IDX_LINK, exc_bank))
    else $error("exception link slot wrong");

  // ----------------------------------------
  // Read port checks
  // ----------------------------------------
  chk_rd_b_data: assert property (
    !rd_b_deny |=> RD_B_DATA == $past(gpr_r[rd_b_phys]))
    else $error("read port b data wrong");
  chk_rd_b_deny: assert property (
    EXEC_STATE == BCRF_ST_HALF && RD_B.idx inside {[4'h8:4'hc]} && !RD_B.high_variant
    |=> RD_B_DENIED && RD_B_DATA == '0)
    else $error("high register reached on port b");
  chk_half_low: assert property (
    EXEC_STATE == BCRF_ST_HALF && !RD_A.idx[3] |=> !RD_A_DENIED)
    else $error("low register denied");
  chk_half_special: assert property (
    EXEC_STATE == BCRF_ST_HALF && RD_A.idx >= `BCRF_IDX_SP |=> !RD_A_DENIED)
    else $error("special register denied");
  chk_word_open: assert property (
    EXEC_STATE != BCRF_ST_HALF |=> !RD_A_DENIED && !RD_B_DENIED)
    else $error("read denied outside halfword state");

  // ----------------------------------------
  // Write and status checks
  // ----------------------------------------
  chk_pc_no_wr: assert property (
    !CTL.pc_en |=> gpr_r[`BCRF_IDX_PC] == $past(gpr_r[`BCRF_IDX_PC]))
    else $error("program counter changed without pc write");
  chk_pc_half: assert property (
    CTL.pc_en && EXEC_STATE == BCRF_ST_HALF |=> gpr_r[`BCRF_IDX_PC][0] == 1'b0)
    else $error("pc not halfword aligned");
  chk_exc_mode: assert property (
    CTL.exc_en |=> cur_mode == $past(CTL.exc_mode))
    else $error("exception mode not entered");
  chk_saved_capture: assert property (
    exc_saved_ok |=> saved_r[$past(saved_idx(exc_bank))] == $past(status_r))
    else $error("saved status not captured");
  chk_saved_write: assert property (
    CTL.saved_en && has_saved && !exc_saved_ok
    |=> saved_r[$past(saved_idx(cur_bank))] == $past(CTL.saved_data))
    else $error("saved status write lost");
  chk_status_out: assert property (
    1'b1 |=> STATUS == $past(status_r))
    else $error("status output stale");
  chk_priv_out: assert property (
    priv |=> PRIVILEGED)
    else $error("privileged mode not flagged");
  chk_saved_valid: assert property (
    has_saved |=> SAVED_VALID && SAVED_STATUS == $past(saved_r[saved_idx(cur_bank)]))
    else $error("saved status not shown");

  cov_fiq_entry: cover property (CTL.exc_en && CTL.exc_mode == `BCRF_MODE_FIQ);
  cov_user_access: cover property (priv && RD_A.user_bank && RD_A.idx == `BCRF_IDX_SP);
  cov_half_high: cover property (EXEC_STATE == BCRF_ST_HALF && RD_A.high_variant && RD_A.idx[3]);
  cov_link_irq: cover property (CTL.link_en && cur_bank == BCRF_BANK_IRQ);
  cov_saved_write: cover property (CTL.saved_en && has_saved);
endmodule : bcrf_core
`default_nettype wire

// File: testbench/bcrf_pipe_model.sv
// Pipeline-side driver model for the register file
`timescale 1ns/1ps
`default_nettype none
module bcrf_pipe_model (
  input wire logic clk,
  input wire logic [31:0] rd_a_data,
  input wire logic [31:0] rd_b_data,
  input wire logic rd_a_denied,
  output var bcrf_pkg::bcrf_state_t state,
  output var bcrf_pkg::bcrf_rd_t rd_a,
  output var bcrf_pkg::bcrf_rd_t rd_b,
  output var bcrf_pkg::bcrf_wr_t wr,
  output var bcrf_pkg::bcrf_ctl_t ctl
);
  import bcrf_pkg::*;
  initial begin
    state = BCRF_ST_WORD;
    rd_a = '0;
    rd_b = '0;
    wr = '0;
    ctl = '0;
  end
  // One-cycle general write
  task automatic put_wr(input logic [3:0] idx, input logic [31:0] d);
    @(posedge clk);
    wr <= '{en: 1'b1, idx: idx, user_bank: 1'b0, data: d};
    @(posedge clk);
    wr <= '0;
  endtask : put_wr
  // One-cycle control pulse
  task automatic put_ctl(input bcrf_ctl_t c);
    @(posedge clk);
    ctl <= c;
    @(posedge clk);
    ctl <= '0;
  endtask : put_ctl
  task automatic set_state(input bcrf_state_t s);
    @(posedge clk);
    state <= s;
  endtask : set_state
  // Both read ports, data taken one cycle after the address
  task automatic get_rd(input bcrf_rd_t r, output logic [31:0] da, output logic [31:0] db, output logic den);
    @(posedge clk);
    rd_a <= r;
    rd_b <= r;
    @(posedge clk);
    #1;
    da = rd_a_data;
    db = rd_b_data;
    den = rd_a_denied;
  endtask : get_rd
endmodule : bcrf_pipe_model
`default_nettype wire

// File: testbench/banked_core_register_file_tb.sv
// Self-checking bench for the banked core register file
`timescale 1ns/1ps
`default_nettype none
`include "bcrf_map.svh"
module banked_core_register_file_tb;
  import bcrf_pkg::*;
  logic clk_sys;
  logic rst_n;
  bcrf_state_t st;
  bcrf_rd_t rda, rdb;
  bcrf_wr_t wr;
  bcrf_ctl_t ctl;
  logic [31:0] rd_a_data, rd_b_data, status, saved_status, pc;
  logic rd_a_denied, rd_b_denied, saved_valid, privileged;
  int n_fail = 0;
  int samples_checked = 0;
  bcrf_core DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .EXEC_STATE(st), .RD_A(rda), .RD_B(rdb), .WR(wr), .CTL(ctl),
    .RD_A_DATA(rd_a_data), .RD_B_DATA(rd_b_data), .RD_A_DENIED(rd_a_denied), .RD_B_DENIED(rd_b_denied),
    .STATUS(status), .SAVED_STATUS(saved_status), .SAVED_VALID(saved_valid), .PROGRAM_COUNTER(pc),
    .PRIVILEGED(privileged));
  bcrf_pipe_model u_pipe (.clk(clk_sys), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .rd_a_denied(rd_a_denied),
    .state(st), .rd_a(rda), .rd_b(rdb), .wr(wr), .ctl(ctl));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic rd_chk(input logic [3:0] i, input logic ub, input logic hv, input logic [31:0] e, input logic dn);
    logic [31:0] da, db;
    logic den;
    u_pipe.get_rd('{idx: i, user_bank: ub, high_variant: hv}, da, db, den);
    chk("read a", da, e);
    chk("read b", db, e);
    chk("denied", {31'h0, den}, {31'h0, dn});
    chk("denied b", {31'h0, rd_b_denied}, {31'h0, dn});
  endtask : rd_chk
  task automatic ctl_op(input logic [1:0] k, input logic [4:0] m, input logic [31:0] v);
    bcrf_ctl_t c;
    c = '0;
    c.exc_en = (k == 2'h0);
    c.exc_mode = m;
    c.exc_return = v;
    c.link_en = (k == 2'h1);
    c.link_addr = v;
    c.status_en = (k == 2'h2);
    c.status_data = v;
    c.pc_en = (k == 2'h3);
    c.pc_data = v;
    u_pipe.put_ctl(c);
    @(posedge clk_sys);
    #1;
  endtask : ctl_op
  task automatic t_reset;
    chk("status", status, `BCRF_STATUS_RESET);
    chk("saved valid", {31'h0, saved_valid}, 32'h1);
    chk("privileged", {31'h0, privileged}, 32'h1);
  endtask : t_reset
  task automatic t_banks;
    u_pipe.put_wr(4'h3, 32'h3333);
    rd_chk(4'h3, 1'b0, 1'b0, 32'h3333, 1'b0);
    u_pipe.put_wr(4'hd, 32'h5ac0);
    u_pipe.put_wr(4'h9, 32'h99);
    ctl_op(2'h0, `BCRF_MODE_IRQ, 32'h1234);
    chk("mode", {27'h0, status[4:0]}, {27'h0, `BCRF_MODE_IRQ});
    chk("saved", saved_status, `BCRF_STATUS_RESET);
    rd_chk(4'he, 1'b0, 1'b0, 32'h1234, 1'b0);
    rd_chk(4'hd, 1'b0, 1'b0, 32'h0, 1'b0);
    rd_chk(4'h9, 1'b0, 1'b0, 32'h99, 1'b0);
    ctl_op(2'h1, 5'h0, 32'h2000);
    rd_chk(4'he, 1'b0, 1'b0, 32'h2000, 1'b0);
    ctl_op(2'h0, `BCRF_MODE_FIQ, 32'h44);
    rd_chk(4'h9, 1'b0, 1'b0, 32'h0, 1'b0);
    rd_chk(4'he, 1'b0, 1'b0, 32'h44, 1'b0);
    u_pipe.put_wr(4'h9, 32'hf9);
    rd_chk(4'h9, 1'b0, 1'b0, 32'hf9, 1'b0);
  endtask : t_banks
  task automatic t_modes;
    bcrf_ctl_t c;
    ctl_op(2'h2, 5'h0, {27'h0, `BCRF_MODE_USR});
    chk("privileged", {31'h0, privileged}, 32'h0);
    chk("saved valid", {31'h0, saved_valid}, 32'h0);
    chk("saved", saved_status, 32'h0);
    rd_chk(4'h9, 1'b0, 1'b0, 32'h99, 1'b0);
    u_pipe.put_wr(4'hd, 32'h77);
    ctl_op(2'h2, 5'h0, {27'h0, `BCRF_MODE_SYS});
    chk("privileged", {31'h0, privileged}, 32'h1);
    chk("saved valid", {31'h0, saved_valid}, 32'h0);
    rd_chk(4'hd, 1'b0, 1'b0, 32'h77, 1'b0);
    ctl_op(2'h2, 5'h0, {27'h0, `BCRF_MODE_SVC});
    rd_chk(4'hd, 1'b0, 1'b0, 32'h5ac0, 1'b0);
    rd_chk(4'hd, 1'b1, 1'b0, 32'h77, 1'b0);
    c = '0;
    c.saved_en = 1'b1;
    c.saved_data = 32'h0000f0d3;
    u_pipe.put_ctl(c);
    @(posedge clk_sys);
    #1;
    chk("saved write", saved_status, 32'h0000f0d3);
  endtask : t_modes
  task automatic t_pc;
    u_pipe.set_state(BCRF_ST_WORD);
    ctl_op(2'h3, 5'h0, 32'h1003);
    chk("pc word", pc, 32'h1000);
    u_pipe.set_state(BCRF_ST_HALF);
    ctl_op(2'h3, 5'h0, 32'h1003);
    chk("pc half", pc, 32'h1002);
    u_pipe.set_state(BCRF_ST_BYTE);
    ctl_op(2'h3, 5'h0, 32'h1003);
    chk("pc byte", pc, 32'h1003);
    u_pipe.put_wr(4'hf, 32'hbeef);
    @(posedge clk_sys);
    #1;
    chk("pc kept", pc, 32'h1003);
  endtask : t_pc
  task automatic t_half;
    u_pipe.set_state(BCRF_ST_HALF);
    rd_chk(4'h9, 1'b0, 1'b0, 32'h0, 1'b1);
    rd_chk(4'h9, 1'b0, 1'b1, 32'h99, 1'b0);
    u_pipe.put_wr(4'ha, 32'hab);
    rd_chk(4'ha, 1'b0, 1'b1, 32'h0, 1'b0);
    rd_chk(4'h3, 1'b0, 1'b0, 32'h3333, 1'b0);
  endtask : t_half
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_banks();
    t_modes();
    t_pc();
    t_half();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    report_and_stop();
  end
endmodule : banked_core_register_file_tb
`default_nettype wire
